// ### rtl/acc_control.sv
`timescale 1ns/1ps
// How it works
// - Bit 6 holds the converter enable; writes store it, reads show 0.
// - Bits 4..2 hold a write-only binary channel number 0..7.
// - Writing 1 to bit 1 starts a conversion on the selected channel.
// - Bit 0 is set by hardware when the core reports a finished result.
// - Reading the register clears bit 0, so each result shows once.
// - Bits 7 and 5 have no function and read as zero.
module acc_control (
	input  wire logic                         clk,
	input  wire logic                         resetn,
	input  wire logic                         ce,
	input  wire logic [7:0]                   sfr_addr,
	input  wire logic                         sfr_wr,
	input  wire logic                         sfr_rd,
	input  wire logic [7:0]                   sfr_wdata,
	output logic      [7:0]                   sfr_rdata,
	output logic                              sfr_hit,
	input  wire logic                         core_done,
	output logic                              converter_enable,
	output logic      [acc_pkg::CHAN_W-1:0]   channel_select,
	output logic      [acc_pkg::NUM_CHAN-1:0] channel_onehot,
	output logic                              conversion_start
);
	import acc_pkg::*;

	// ------------------------------------------------------------
	// Local sizes
	// ------------------------------------------------------------
	localparam int REG_W = 8;

	// ------------------------------------------------------------
	// Decode helpers
	// ------------------------------------------------------------
	// Byte writes and single-bit writes both arrive as one strobe
	function automatic logic addr_match(
		input logic [REG_W-1:0] addr
	);
		return (addr == CONV_CTRL_ADDR);
	endfunction : addr_match

	function automatic logic [CHAN_W-1:0] chan_field(
		input logic [REG_W-1:0] data
	);
		return data[CHAN_HI:CHAN_LO];
	endfunction : chan_field

	function automatic logic bit_field(
		input logic [REG_W-1:0] data,
		input int               pos
	);
		return data[pos];
	endfunction : bit_field

	// ------------------------------------------------------------
	// Completion flag states
	// ------------------------------------------------------------
	typedef enum logic [1:0] {
		FLAG_CLEAR = 2'b01,
		FLAG_SET   = 2'b10
	} acc_flag_state_t;

	// ------------------------------------------------------------
	// Declarations
	// ------------------------------------------------------------
	acc_flag_state_t   flag_state;
	acc_flag_state_t   next_flag_state;
	logic              conversion_done_flag;
	logic              next_converter_enable;
	logic [CHAN_W-1:0] next_channel_select;
	logic              next_conversion_start;
	logic [REG_W-1:0]  next_rdata;
	logic              wr_hit;
	logic              rd_hit;
	logic              cfg_wr;
	logic              start_wr;
	wire  [REG_W-1:0]  read_view;

	// Every register below moves only while ce is high; a low ce
	// also holds conversion_start, and a start written meanwhile is dropped

	// ------------------------------------------------------------
	// Address decode
	// ------------------------------------------------------------
	assign sfr_hit = addr_match(sfr_addr);
	assign wr_hit  = sfr_wr && addr_match(sfr_addr);
	assign rd_hit  = sfr_rd && addr_match(sfr_addr);

	// ------------------------------------------------------------
	// Write strobes per field group
	// ------------------------------------------------------------
	// Every write reloads the configuration fields
	assign cfg_wr   = wr_hit;
	assign start_wr = wr_hit && bit_field(sfr_wdata, START_BIT);

	// ------------------------------------------------------------
	// Configuration: enable and channel number
	// ------------------------------------------------------------
	// A channel change reaches channel_onehot one cycle later, even during a conversion
	always_comb begin
		next_converter_enable = converter_enable;
		next_channel_select   = channel_select;
		if (cfg_wr) begin
			next_converter_enable = bit_field(sfr_wdata, ENABLE_BIT);
			next_channel_select   = chan_field(sfr_wdata);
		end
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			converter_enable <= CONV_CTRL_RESET[ENABLE_BIT];
			channel_select   <= CHAN_RESET;
		end else if (ce) begin
			converter_enable <= next_converter_enable;
			channel_select   <= next_channel_select;
		end
	end

	// ------------------------------------------------------------
	// Start request
	// ------------------------------------------------------------
	// The start bit is never stored, so a later write of the other
	// fields cannot launch a second conversion by accident
	always_comb begin
		next_conversion_start = 1'b0;
		if (start_wr) begin
			next_conversion_start = 1'b1;
		end
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			conversion_start <= 1'b0;
		end else if (ce) begin
			conversion_start <= next_conversion_start;
		end
	end

	// ------------------------------------------------------------
	// Completion flag
	// ------------------------------------------------------------
	// Set wins over the read clear: the read returns the old value
	// and the flag stays up, so no finished result is lost
	assign conversion_done_flag = (flag_state == FLAG_SET);

	always_comb begin
		next_flag_state = flag_state;
		unique case (flag_state)
			FLAG_CLEAR: begin
				if (core_done) begin
					next_flag_state = FLAG_SET;
				end
			end
			FLAG_SET: begin
				// A done in the same cycle keeps the flag up
				if (rd_hit && !core_done) begin
					next_flag_state = FLAG_CLEAR;
				end
			end
			default: begin
				// Illegal code falls back to a clean state
				next_flag_state = FLAG_CLEAR;
			end
		endcase
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			flag_state <= FLAG_CLEAR;
		end else if (ce) begin
			flag_state <= next_flag_state;
		end
	end

	// ------------------------------------------------------------
	// Read view
	// ------------------------------------------------------------
	// Write-only and reserved positions read as zero
	for (genvar b = 0; b < REG_W; b++) begin : g_read_view
		if (b == DONE_BIT) begin : g_flag
			assign read_view[b] = conversion_done_flag;
		end else begin : g_zero
			assign read_view[b] = 1'b0;
		end
	end

	// ------------------------------------------------------------
	// Read data
	// ------------------------------------------------------------
	// Zero between reads keeps a stale flag off the bus
	always_comb begin
		next_rdata = 8'h00;
		if (rd_hit) begin
			next_rdata = read_view;
		end
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			sfr_rdata <= 8'h00;
		end else if (ce) begin
			sfr_rdata <= next_rdata;
		end
	end

	// ------------------------------------------------------------
	// Channel decode
	// ------------------------------------------------------------
	// Registered so the input multiplexer sees a clean select

	acc_chan_decode #(
		.NUM_CHAN (NUM_CHAN),
		.CHAN_W   (CHAN_W)
	) u_decode (
		.clk         (clk),
		.resetn      (resetn),
		.ce          (ce),
		.chan_code   (channel_select),
		.chan_onehot (channel_onehot)
	);
endmodule : acc_control

// ### rtl/acc_pkg.sv
package acc_pkg;
	// ------------------------------------------------------------
	// Register map
	// ------------------------------------------------------------
	localparam logic [7:0] CONV_CTRL_ADDR   = 8'h84;
	localparam logic [7:0] CONV_CTRL_RESET  = 8'h00;
	localparam int         ENABLE_BIT       = 6;
	localparam int         CHAN_HI          = 4;
	localparam int         CHAN_LO          = 2;
	localparam int         START_BIT        = 1;
	localparam int         DONE_BIT         = 0;
	localparam int         RSVD_HI_BIT      = 7;
	localparam int         RSVD_LO_BIT      = 5;
	localparam int         CHAN_W           = 3;
	localparam int         NUM_CHAN         = 8;
	localparam logic [2:0] CHAN_RESET       = 3'h0;
endpackage : acc_pkg

// ### rtl/acc_chan_decode.sv
`timescale 1ns/1ps
// ------------------------------------------------------------
// One-hot channel decoder, registered
// ------------------------------------------------------------
module acc_chan_decode #(
	parameter int NUM_CHAN = acc_pkg::NUM_CHAN,
	parameter int CHAN_W   = acc_pkg::CHAN_W
) (
	input  wire logic                clk,
	input  wire logic                resetn,
	input  wire logic                ce,
	input  wire logic [CHAN_W-1:0]   chan_code,
	output logic      [NUM_CHAN-1:0] chan_onehot
);
	import acc_pkg::*;

	logic [NUM_CHAN-1:0] next_chan_onehot;

	always_comb begin
		next_chan_onehot = '0;
		for (int i = 0; i < NUM_CHAN; i++) begin
			// Binary code i selects channel i
			next_chan_onehot[i] = (chan_code == i[CHAN_W-1:0]);
		end
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			chan_onehot <= {{(NUM_CHAN-1){1'b0}}, 1'b1};
		end else if (ce) begin
			chan_onehot <= next_chan_onehot;
		end
	end
endmodule : acc_chan_decode

// ### bench/acc_core_model.sv
`timescale 1ns/1ps
module acc_core_model(input wire logic clk,resetn,conversion_start,
	input wire logic [3:0] core_delay,output logic core_done);
	logic [4:0] left;
	// Latency per start from bench: prompt and slow answers
	always_ff @(posedge clk or negedge resetn)
		if(!resetn) left<=5'h00;
		else left<=conversion_start?core_delay+5'h01:left-5'(left!=0);
	assign core_done=left==5'h01;
endmodule : acc_core_model

// ### bench/acc_control_props.sv
`timescale 1ns/1ps
module acc_control_props(input wire logic clk,resetn,ce,sfr_wr,sfr_rd,
	input wire logic core_done,converter_enable,conversion_start,
	input wire logic [7:0] sfr_addr,sfr_wdata,sfr_rdata,channel_onehot,
	input wire logic [2:0] channel_select);
	default clocking @(posedge clk); endclocking
	default disable iff (!resetn);
	wire hit=sfr_addr==acc_pkg::CONV_CTRL_ADDR;
	wire wr=ce&&sfr_wr&&hit;
	wire go=wr&&sfr_wdata[1];
	sequence s_rd; ce&&sfr_rd&&hit; endsequence
	sequence s_done; ce&&core_done; endsequence
	chk_en_store: assert property(wr|=>
		converter_enable==$past(sfr_wdata[6])) else $error("enable");
	chk_chan_store: assert property(wr|=>
		channel_select==$past(sfr_wdata[4:2])) else $error("channel");
	chk_onehot_track: assert property(ce|=>
		channel_onehot==8'h01<<$past(channel_select)) else $error("onehot");
	chk_start_pulse: assert property(ce|=>
		conversion_start==$past(go)) else $error("start");
	chk_done_seen: assert property(s_done ##1 s_rd|=>
		sfr_rdata[0]) else $error("flag");
	chk_read_clear: assert property(s_rd ##0 !core_done ##1
		ce&&!core_done ##1 s_rd|=>!sfr_rdata[0]) else $error("clear");
	chk_rsvd_zero: assert property(ce|=>
		sfr_rdata[7:1]==7'h00) else $error("reserved");
endmodule : acc_control_props
bind acc_control acc_control_props i_props(.*);

// ### bench/tb_acc_control.sv
`timescale 1ns/1ps
module tb_acc_control;
	logic clk=0,resetn=0,ce=1,sfr_wr=0,sfr_rd=0,core_done,sfr_hit;
	logic converter_enable,conversion_start;
	logic [7:0] sfr_addr=0,sfr_wdata=0,sfr_rdata,channel_onehot,rn=8'h55,wd;
	logic [2:0] channel_select;
	logic [3:0] core_delay=0;
	int fails=0,checks=0;
	wire [4:0] outs={converter_enable,channel_select,conversion_start};
	acc_control i_dut(.*);
	acc_core_model i_core(.*);
	always #25 clk=~clk;
	function automatic logic [7:0] lfsr(input logic [7:0] s);
		return {s[6:0],s[7]^s[5]^s[4]^s[3]};
	endfunction : lfsr
	function automatic logic [4:0] want(input logic [7:0] d);
		return {d[6],d[4:2],d[1]};
	endfunction : want
	task cmp(input logic [15:0] g,e);
		checks++;
		if(g!==e) begin fails++;
			$display("CHECK FAILED %0t got %h want %h",$time,g,e); end
	endtask : cmp
	task acc(input logic [7:0] a,d,input logic w);
		@(posedge clk) {sfr_addr,sfr_wdata,sfr_wr,sfr_rd}<={a,d,w,!w};
		@(posedge clk) {sfr_wr,sfr_rd}<=2'h0;
		#1;
	endtask : acc
	task test_done;
		$display("checks %0d fails %0d",checks,fails);
		if(fails==0&&checks>0) $display("Simulation passed");
		else $display("Simulation failed");
		$finish;
	endtask : test_done
	initial begin
		#100000 fails++;
		test_done;
	end
	initial begin
		repeat(10) @(posedge clk);
		resetn<=1;
		acc(8'h85,8'hff,1);
		acc(8'h85,0,0);
		cmp({sfr_rdata,outs},0);
		cmp(sfr_hit,0);
		for(int i=0;i<8;i++) begin
			rn=lfsr(rn);
			core_delay<=rn[3:0];
			wd={rn[7:5],i[2:0],1'b1,rn[0]};
			acc(8'h84,wd,1);
			cmp(outs,want(wd));
			@(posedge clk) #1 cmp({channel_onehot,outs[0]},{8'h01<<i,1'b0});
			for(int k=0;k<20&&!core_done;k++) @(posedge clk) #1;
			acc(8'h84,0,0);
			cmp(sfr_rdata,1);
			cmp(sfr_hit,1);
			acc(8'h84,0,0);
			cmp(sfr_rdata,0);
		end
		ce<=0;
		acc(8'h84,~wd,1);
		cmp(outs,want(wd)&5'h1e);
		ce<=1;
		test_done;
	end
endmodule : tb_acc_control
